// >>> gp_pkg.sv
// constants used by the port block, including the width it gives its pin synchroniser
package gp_pkg;

    // ----------------------------------------
    // widths
    // ----------------------------------------
    localparam int PORT_W = 8;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 8;
    localparam int IT_W = 12;
    localparam int SYNC_W = 24;

    // ----------------------------------------
    // register offsets
    // ----------------------------------------
    localparam logic [7:0] OFF_PA_DATA = 8'h00;
    localparam logic [7:0] OFF_PA_DIR = 8'h01;
    localparam logic [7:0] OFF_PB_DATA = 8'h02;
    localparam logic [7:0] OFF_PB_DIR = 8'h03;
    localparam logic [7:0] OFF_PC_DATA = 8'h04;
    localparam logic [7:0] OFF_PC_DIR = 8'h05;
    localparam logic [7:0] OFF_INT_FIRST = 8'h08;
    localparam logic [7:0] OFF_INT_SECOND = 8'h09;
    localparam logic [7:0] OFF_INT_SENSE = 8'h0A;
    localparam logic [7:0] OFF_MISC = 8'h0B;

    // ----------------------------------------
    // reset values and field layout
    // ----------------------------------------
    localparam logic [7:0] RST_VAL = 8'h00;
    localparam logic [7:0] SECOND_MASK = 8'h0F;
    localparam logic [7:0] SENSE_MASK = 8'h3F;
    localparam logic [7:0] MISC_MASK = 8'h03;
    localparam int MISC_MCO_BIT = 0;
    localparam int MISC_USB_TX_ENABLE_OUT_BIT = 1;
    localparam int SENSE_A_LSB = 0;
    localparam int SENSE_B_LSB = 2;
    localparam int SENSE_C_LSB = 4;
    localparam logic [7:0] PC_OPEN_DRAIN = 8'h03;
    localparam logic [7:0] PC_PULL_UP = 8'hFC;

    // ----------------------------------------
    // interrupt sensitivity codes
    // ----------------------------------------
    localparam logic [1:0] SENSE_LOW_FALL = 2'h0;
    localparam logic [1:0] SENSE_RISE = 2'h1;
    localparam logic [1:0] SENSE_FALL = 2'h2;
    localparam logic [1:0] SENSE_BOTH = 2'h3;

endpackage : gp_pkg

// >>> gp_sync_if.sv
// synchronised pin levels and edges passed from the synchroniser to the port logic
`timescale 1ns/1ps
interface gp_sync_if #(
    parameter int W = 8
);
    logic [W-1:0] level;
    logic [W-1:0] rise;
    logic [W-1:0] fall;
    modport src (output level, output rise, output fall);
    modport dst (input level, input rise, input fall);
endinterface : gp_sync_if

// >>> gp_pin_sync.sv
// three-stage pin synchroniser with agreement filter and edge detect
`timescale 1ns/1ps
module gp_pin_sync #(
    parameter int W = 8
) (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic [W-1:0] pin_in,
    gp_sync_if.src sync_if
);

    // ----------------------------------------
    // sampling chain
    // ----------------------------------------
    logic [W-1:0] s1_reg;
    logic [W-1:0] s2_reg;
    logic [W-1:0] s3_reg;
    logic [W-1:0] filt_reg;
    logic [W-1:0] filt_next;
    logic [W-1:0] prev_reg;
    wire [W-1:0] differ = s2_reg ^ s3_reg;

    // a change counts only once stages two and three agree
    assign filt_next = (~differ & s3_reg) | (differ & filt_reg);

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            s1_reg <= '0;
            s2_reg <= '0;
            s3_reg <= '0;
            filt_reg <= '0;
            prev_reg <= '0;
        end else begin
            s1_reg <= pin_in;
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
            filt_reg <= filt_next;
            prev_reg <= filt_reg;
        end
    end

    // ----------------------------------------
    // edges against the registered previous sample
    // ----------------------------------------
    assign sync_if.level = filt_reg;
    assign sync_if.rise = filt_reg & ~prev_reg; // RL23
    assign sync_if.fall = ~filt_reg & prev_reg; // RL23

endmodule : gp_pin_sync

// >>> gp_port_top.sv
// three 8-bit general-purpose ports with external interrupts and alternate functions
// Notes on behaviour
// RL1: cleared direction bit makes that pin input
// RL2: input pin data read returns pin level
// RL3: set direction bit makes that pin output
// RL4: output drives latch; read returns the latch
// RL5: output-mode pins never raise external interrupts
// RL6: software loads latch before switching to output
// RL7: each enabled input pin requests with own sensitivity; here the four pins of each group share one 2-bit sensitivity code
// RL8: grouped requests are ANDed low then inverted
// RL9: active alternate function overrides data and direction
// RL10: peripheral output forces drive, push-pull or open-drain
// RL11: peripheral input pins stay readable through data
// RL12: bidirectional peripheral pins keep direction bit zero
// RL13: no alternate function with interrupt enabled together
// RL14: analog input pins stay configured as input
// RL15: port A floating, USB enable, interrupts 1-4
// RL16: channel code N selects analog pin A N
// RL17: port B clock out, serial, timer clock
// RL18: B4/B5 timer captures and interrupts 5-6
// RL19: B6/B7 PWM outputs and interrupts 7-8
// RL20: port C open drain, pull-ups, SPI, interrupts 9-12
// RL21: sensitivity code picks low-level, rise, fall, both
// RL22: data writes update latch even in input mode
// RL23: interrupt inputs synchronised; edges from previous sample
//
// The implementer's own choices: the placing of the registers and strobed register access.
`timescale 1ns/1ps
module gp_port_top (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic [7:0] addr,
    input wire logic [7:0] wr_data,
    input wire logic wr_stb,
    input wire logic rd_stb,
    output logic [7:0] rd_data,
    input wire logic [7:0] port_a_pin_in,
    output logic [7:0] port_a_pin_out,
    output logic [7:0] port_a_pin_oe_n,
    input wire logic [7:0] port_b_pin_in,
    output logic [7:0] port_b_pin_out,
    output logic [7:0] port_b_pin_oe_n,
    input wire logic [7:0] port_c_pin_in,
    output logic [7:0] port_c_pin_out,
    output logic [7:0] port_c_pin_oe_n,
    output logic [7:0] port_c_pull_up,
    input wire logic usb_tx_enable_out,
    input wire logic serial_enable,
    input wire logic serial_tx_data,
    input wire logic tx_enable,
    input wire logic ext_clock_select,
    input wire logic timer_enable,
    input wire logic [1:0] pwm_out,
    input wire logic [1:0] pwm_out_enable,
    input wire logic spi_enable,
    input wire logic [3:0] spi_out,
    input wire logic [3:0] spi_drive,
    input wire logic [2:0] adc_channel,
    output logic [2:0] ext_irq,
    output logic serial_rx_in,
    output logic reload_timer_ext_clk,
    output logic [1:0] timer_capture_in,
    output logic [3:0] spi_in,
    output logic [7:0] analog_sel
);

    // ----------------------------------------
    // helpers
    // ----------------------------------------
    function automatic logic [7:0] port_read(input logic [7:0] dir, input logic [7:0] latch,
                                             input logic [7:0] lvl);
        port_read = (dir & latch) | (~dir & lvl); // RL2 RL4 RL11
    endfunction : port_read

    function automatic logic [7:0] merge_val(input logic [7:0] alt_drv, input logic [7:0] alt_val,
                                             input logic [7:0] latch);
        merge_val = (alt_drv & alt_val) | (~alt_drv & latch); // RL9
    endfunction : merge_val

    function automatic logic [3:0] sense_event(input logic [1:0] code, input logic [3:0] lvl,
                                               input logic [3:0] rise, input logic [3:0] fall);
        if (code == gp_pkg::SENSE_LOW_FALL) begin // RL21
            sense_event = ~lvl | fall;
        end else if (code == gp_pkg::SENSE_RISE) begin
            sense_event = rise;
        end else if (code == gp_pkg::SENSE_FALL) begin
            sense_event = fall;
        end else begin
            sense_event = rise | fall;
        end
    endfunction : sense_event

    // ----------------------------------------
    // software registers
    // ----------------------------------------
    logic [7:0] data_a_reg;
    logic [7:0] dir_a_reg;
    logic [7:0] data_b_reg;
    logic [7:0] dir_b_reg;
    logic [7:0] data_c_reg;
    logic [7:0] dir_c_reg;
    logic [7:0] ext_int_ctrl_first_reg;
    logic [7:0] ext_int_ctrl_second_reg;
    logic [7:0] int_sense_reg;
    logic [7:0] misc_ctrl_reg;
    logic main_clock_out_reg;

    wire wr_pa_data = wr_stb && (addr == gp_pkg::OFF_PA_DATA);
    wire wr_pa_dir = wr_stb && (addr == gp_pkg::OFF_PA_DIR);
    wire wr_pb_data = wr_stb && (addr == gp_pkg::OFF_PB_DATA);
    wire wr_pb_dir = wr_stb && (addr == gp_pkg::OFF_PB_DIR);
    wire wr_pc_data = wr_stb && (addr == gp_pkg::OFF_PC_DATA);
    wire wr_pc_dir = wr_stb && (addr == gp_pkg::OFF_PC_DIR);
    wire wr_first = wr_stb && (addr == gp_pkg::OFF_INT_FIRST);
    wire wr_second = wr_stb && (addr == gp_pkg::OFF_INT_SECOND);
    wire wr_sense = wr_stb && (addr == gp_pkg::OFF_INT_SENSE);
    wire wr_misc = wr_stb && (addr == gp_pkg::OFF_MISC);

    // latch takes every write whatever the direction, so output starts at the stored level
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            data_a_reg <= gp_pkg::RST_VAL;
            data_b_reg <= gp_pkg::RST_VAL;
            data_c_reg <= gp_pkg::RST_VAL;
        end else begin
            if (wr_pa_data) data_a_reg <= wr_data; // RL22
            if (wr_pb_data) data_b_reg <= wr_data; // RL22
            if (wr_pc_data) data_c_reg <= wr_data; // RL22
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            dir_a_reg <= gp_pkg::RST_VAL;
            dir_b_reg <= gp_pkg::RST_VAL;
            dir_c_reg <= gp_pkg::RST_VAL;
        end else begin
            if (wr_pa_dir) dir_a_reg <= wr_data; // RL1 RL3
            if (wr_pb_dir) dir_b_reg <= wr_data;
            if (wr_pc_dir) dir_c_reg <= wr_data;
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            ext_int_ctrl_first_reg <= gp_pkg::RST_VAL;
            ext_int_ctrl_second_reg <= gp_pkg::RST_VAL;
            int_sense_reg <= gp_pkg::RST_VAL;
            misc_ctrl_reg <= gp_pkg::RST_VAL;
        end else begin
            if (wr_first) ext_int_ctrl_first_reg <= wr_data;
            if (wr_second) ext_int_ctrl_second_reg <= wr_data & gp_pkg::SECOND_MASK;
            if (wr_sense) int_sense_reg <= wr_data & gp_pkg::SENSE_MASK;
            if (wr_misc) misc_ctrl_reg <= wr_data & gp_pkg::MISC_MASK;
        end
    end

    // ----------------------------------------
    // pin synchronisation
    // ----------------------------------------
    gp_sync_if #(.W(gp_pkg::SYNC_W)) sync_bus ();

    gp_pin_sync #(.W(gp_pkg::SYNC_W)) u_sync (
        .clk(clk),
        .reset_n(reset_n),
        .pin_in({port_c_pin_in, port_b_pin_in, port_a_pin_in}),
        .sync_if(sync_bus.src)
    );

    wire [7:0] lvl_a = sync_bus.level[7:0];
    wire [7:0] lvl_b = sync_bus.level[15:8];
    wire [7:0] lvl_c = sync_bus.level[23:16];

    // ----------------------------------------
    // alternate functions and pin drive
    // ----------------------------------------
    // clock out is a divided toggle: every output must leave a flip-flop
    wire mco_on = misc_ctrl_reg[gp_pkg::MISC_MCO_BIT];
    wire usb_tx_enable_out_on = misc_ctrl_reg[gp_pkg::MISC_USB_TX_ENABLE_OUT_BIT];
    wire [3:0] spi_drv = spi_enable ? spi_drive : 4'h0;

    wire [7:0] alt_drv_a = {7'h00, usb_tx_enable_out_on}; // RL15
    wire [7:0] alt_val_a = {7'h00, usb_tx_enable_out}; // RL15
    wire [7:0] alt_drv_b = {pwm_out_enable, 3'h0, tx_enable, 1'h0, mco_on}; // RL17 RL19
    wire [7:0] alt_val_b = {pwm_out, 3'h0, serial_tx_data, 1'h0, main_clock_out_reg}; // RL17 RL19
    wire [7:0] alt_drv_c = {1'h0, spi_drv, 3'h0}; // RL20
    wire [7:0] alt_val_c = {1'h0, spi_out, 3'h0}; // RL20

    wire [7:0] drive_a = alt_drv_a | dir_a_reg; // RL10
    wire [7:0] drive_b = alt_drv_b | dir_b_reg; // RL10
    wire [7:0] drive_c = alt_drv_c | dir_c_reg; // RL10
    wire [7:0] val_a = merge_val(alt_drv_a, alt_val_a, data_a_reg); // RL4
    wire [7:0] val_b = merge_val(alt_drv_b, alt_val_b, data_b_reg);
    wire [7:0] val_c = merge_val(alt_drv_c, alt_val_c, data_c_reg);

    // open-drain bits only pull low, a one releases the pin
    wire [7:0] oe_n_c_next = ~(drive_c & ~(gp_pkg::PC_OPEN_DRAIN & val_c)); // RL20
    wire [7:0] out_c_next = val_c & ~gp_pkg::PC_OPEN_DRAIN;

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            port_a_pin_out <= 8'h00;
            port_a_pin_oe_n <= 8'hFF;
            port_b_pin_out <= 8'h00;
            port_b_pin_oe_n <= 8'hFF;
            port_c_pin_out <= 8'h00;
            port_c_pin_oe_n <= 8'hFF;
            port_c_pull_up <= gp_pkg::PC_PULL_UP;
            main_clock_out_reg <= 1'h0;
        end else begin
            port_a_pin_out <= val_a; // RL4
            port_a_pin_oe_n <= ~drive_a; // RL1 RL3
            port_b_pin_out <= val_b;
            port_b_pin_oe_n <= ~drive_b;
            port_c_pin_out <= out_c_next;
            port_c_pin_oe_n <= oe_n_c_next;
            port_c_pull_up <= gp_pkg::PC_PULL_UP & ~drive_c; // RL20
            main_clock_out_reg <= mco_on ? ~main_clock_out_reg : 1'h0; // RL17
        end
    end

    // ----------------------------------------
    // peripheral inputs and analog select
    // ----------------------------------------
    wire [7:0] analog_sel_next = 8'h01 << adc_channel; // RL16

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            serial_rx_in <= 1'h1;
            reload_timer_ext_clk <= 1'h0;
            timer_capture_in <= 2'h0;
            spi_in <= 4'h0;
            analog_sel <= 8'h01;
        end else begin
            serial_rx_in <= serial_enable ? lvl_b[1] : 1'h1; // RL17
            reload_timer_ext_clk <= ext_clock_select & lvl_b[3]; // RL17
            timer_capture_in <= timer_enable ? lvl_b[5:4] : 2'h0; // RL18
            spi_in <= spi_enable ? lvl_c[6:3] : 4'h0; // RL20
            analog_sel <= analog_sel_next; // RL16
        end
    end

    // ----------------------------------------
    // external interrupts
    // ----------------------------------------
    wire [11:0] it_lvl = {lvl_c[5:2], lvl_b[7:4], lvl_a[3:0]}; // RL15 RL18 RL19 RL20
    wire [11:0] it_rise = {sync_bus.rise[21:18], sync_bus.rise[15:12], sync_bus.rise[3:0]};
    wire [11:0] it_fall = {sync_bus.fall[21:18], sync_bus.fall[15:12], sync_bus.fall[3:0]};
    wire [11:0] it_en = {ext_int_ctrl_second_reg[3:0], ext_int_ctrl_first_reg};
    wire [11:0] it_out = {drive_c[5:2], drive_b[7:4], drive_a[3:0]};
    wire [11:0] it_event;

    assign it_event[3:0] = sense_event(int_sense_reg[gp_pkg::SENSE_A_LSB +: 2], it_lvl[3:0],
                                       it_rise[3:0], it_fall[3:0]); // RL21
    assign it_event[7:4] = sense_event(int_sense_reg[gp_pkg::SENSE_B_LSB +: 2], it_lvl[7:4],
                                       it_rise[7:4], it_fall[7:4]); // RL21
    assign it_event[11:8] = sense_event(int_sense_reg[gp_pkg::SENSE_C_LSB +: 2], it_lvl[11:8],
                                        it_rise[11:8], it_fall[11:8]); // RL21

    // requests are active low inside; any pin low pulls its whole vector
    wire [11:0] it_req_n = ~(it_event & it_en & ~it_out); // RL5 RL7
    wire [2:0] irq_next = {~&it_req_n[11:8], ~&it_req_n[7:4], ~&it_req_n[3:0]}; // RL8

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            ext_irq <= 3'h0;
        end else begin
            ext_irq <= irq_next; // RL7 RL8
        end
    end

    // ----------------------------------------
    // read port
    // ----------------------------------------
    wire [7:0] rd_next =
        (addr == gp_pkg::OFF_PA_DATA) ? port_read(dir_a_reg, data_a_reg, lvl_a) :
        (addr == gp_pkg::OFF_PA_DIR) ? dir_a_reg :
        (addr == gp_pkg::OFF_PB_DATA) ? port_read(dir_b_reg, data_b_reg, lvl_b) :
        (addr == gp_pkg::OFF_PB_DIR) ? dir_b_reg :
        (addr == gp_pkg::OFF_PC_DATA) ? port_read(dir_c_reg, data_c_reg, lvl_c) :
        (addr == gp_pkg::OFF_PC_DIR) ? dir_c_reg :
        (addr == gp_pkg::OFF_INT_FIRST) ? ext_int_ctrl_first_reg :
        (addr == gp_pkg::OFF_INT_SECOND) ? ext_int_ctrl_second_reg :
        (addr == gp_pkg::OFF_INT_SENSE) ? int_sense_reg :
        (addr == gp_pkg::OFF_MISC) ? misc_ctrl_reg : 8'h00;

    // data stand one cycle only, zero between reads
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            rd_data <= 8'h00;
        end else begin
            rd_data <= rd_stb ? rd_next : 8'h00;
        end
    end

    // ----------------------------------------
    // assertions
    // ----------------------------------------
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!reset_n);

    property p_dir_input;
        !dir_a_reg[3] |=> port_a_pin_oe_n[3];
    endproperty
    a_dir_input: assert property (p_dir_input) else $error("input pin is driven"); // RL1

    property p_dir_output;
        dir_b_reg[5] |=> !port_b_pin_oe_n[5] && port_b_pin_out[5] == $past(data_b_reg[5]);
    endproperty
    a_dir_output: assert property (p_dir_output) else $error("output pin not driving latch"); // RL3

    property p_read_input;
        rd_stb && addr == gp_pkg::OFF_PA_DATA && dir_a_reg == 8'h00 |=> rd_data == $past(lvl_a);
    endproperty
    a_read_input: assert property (p_read_input) else $error("input read is not pin level"); // RL2

    property p_read_latch;
        rd_stb && addr == gp_pkg::OFF_PB_DATA && dir_b_reg == 8'hFF |=> rd_data == $past(data_b_reg);
    endproperty
    a_read_latch: assert property (p_read_latch) else $error("output read is not latch"); // RL4

    property p_out_suppress;
        dir_a_reg[3:0] == 4'hF |=> !ext_irq[0];
    endproperty
    a_out_suppress: assert property (p_out_suppress) else $error("output pin raised interrupt"); // RL5

    property p_group_req;
        (it_event[7:4] & it_en[7:4] & ~it_out[7:4]) != 4'h0 |=> ext_irq[1];
    endproperty
    a_group_req: assert property (p_group_req) else $error("enabled event lost"); // RL7 RL8

    property p_no_req;
        (it_en[11:8] == 4'h0) |=> !ext_irq[2];
    endproperty
    a_no_req: assert property (p_no_req) else $error("disabled group raised interrupt"); // RL7

    property p_rise_only;
        int_sense_reg[1:0] == gp_pkg::SENSE_RISE && it_rise[3:0] == 4'h0 |=> !ext_irq[0];
    endproperty
    a_rise_only: assert property (p_rise_only) else $error("rise mode fired without rise"); // RL21

    property p_alt_usb;
        usb_tx_enable_out_on |=> !port_a_pin_oe_n[0] && port_a_pin_out[0] == $past(usb_tx_enable_out);
    endproperty
    a_alt_usb: assert property (p_alt_usb) else $error("alternate output not selected"); // RL9 RL10

    property p_open_drain;
        port_c_pin_out[1:0] == 2'h0 ##0 !port_c_pin_oe_n[0] |-> $past(val_c[0]) == 1'h0;
    endproperty
    a_open_drain: assert property (p_open_drain) else $error("open drain drove high"); // RL20

    property p_adc_sel;
        1'b1 |=> analog_sel == (8'h01 << $past(adc_channel));
    endproperty
    a_adc_sel: assert property (p_adc_sel) else $error("wrong analog channel"); // RL16

    property p_latch_in_input;
        wr_pc_data && !dir_c_reg[7] |=> data_c_reg == $past(wr_data)
            ##1 port_c_pin_out[7] == $past(data_c_reg[7]);
    endproperty
    a_latch_in_input: assert property (p_latch_in_input) else $error("latch write lost"); // RL22

    c_irq_a: cover property (!ext_irq[0] ##1 ext_irq[0]);
    c_rd_input: cover property (rd_stb && addr == gp_pkg::OFF_PC_DATA && dir_c_reg == 8'h00);
    c_spi_drive: cover property (spi_enable && spi_drive != 4'h0);
    c_mco: cover property (mco_on [*3]);

endmodule : gp_port_top

// >>> gp_pin_model.sv
// far-side pin model: external drivers, pull-ups and floating lines
`timescale 1ns/1ps
module gp_pin_model (
    input wire logic clk,
    input wire logic [7:0] pin_out,
    input wire logic [7:0] pin_oe_n,
    input wire logic [7:0] pull_up,
    input wire logic [7:0] ext_val,
    input wire logic [7:0] ext_en,
    output logic [7:0] pin_level
);
    // ----------------------------------------
    // wire resolution
    // ----------------------------------------
    // undriven floating lines wander so a stale level never passes
    logic [7:0] float_reg = 8'h00;
    always @(posedge clk) float_reg <= ~float_reg;
    always_comb begin
        for (int i = 0; i < 8; i++) begin
            if (!pin_oe_n[i]) pin_level[i] = pin_out[i];
            else if (ext_en[i]) pin_level[i] = ext_val[i];
            else if (pull_up[i]) pin_level[i] = 1'b1;
            else pin_level[i] = float_reg[i];
        end
    end
endmodule : gp_pin_model

// >>> gpio_port_pin_control_test.sv
// self-checking bench for the port block
`timescale 1ns/1ps
module gpio_port_pin_control_test;
    logic clk, reset_n, wr_stb, rd_stb, usb_tx_enable_out, serial_enable, serial_tx_data, tx_enable;
    logic ext_clock_select, timer_enable, spi_enable, prev_irq, mco_seen;
    logic [7:0] addr, wr_data, rd_data, a_in, a_out, a_oe_n, b_in, b_out, b_oe_n, c_in, c_out, c_oe_n, pull_up;
    logic [7:0] analog_sel, xa, xb, xc, xc_en;
    logic [1:0] pwm_out, pwm_out_enable, timer_capture_in;
    logic [3:0] spi_out, spi_drive, spi_in;
    logic [2:0] adc_channel, ext_irq;
    logic serial_rx_in, reload_timer_ext_clk;
    int errors = 0, cmp_count = 0, pulses = 0;

    gp_port_top uut (.clk(clk), .reset_n(reset_n), .addr(addr), .wr_data(wr_data), .wr_stb(wr_stb),
        .rd_stb(rd_stb), .rd_data(rd_data), .port_a_pin_in(a_in), .port_a_pin_out(a_out),
        .port_a_pin_oe_n(a_oe_n), .port_b_pin_in(b_in), .port_b_pin_out(b_out), .port_b_pin_oe_n(b_oe_n),
        .port_c_pin_in(c_in), .port_c_pin_out(c_out), .port_c_pin_oe_n(c_oe_n), .port_c_pull_up(pull_up),
        .usb_tx_enable_out(usb_tx_enable_out), .serial_enable(serial_enable), .serial_tx_data(serial_tx_data),
        .tx_enable(tx_enable), .ext_clock_select(ext_clock_select), .timer_enable(timer_enable),
        .pwm_out(pwm_out), .pwm_out_enable(pwm_out_enable), .spi_enable(spi_enable), .spi_out(spi_out),
        .spi_drive(spi_drive), .adc_channel(adc_channel), .ext_irq(ext_irq), .serial_rx_in(serial_rx_in),
        .reload_timer_ext_clk(reload_timer_ext_clk), .timer_capture_in(timer_capture_in), .spi_in(spi_in),
        .analog_sel(analog_sel));
    gp_pin_model pa (.clk(clk), .pin_out(a_out), .pin_oe_n(a_oe_n), .pull_up(8'h00), .ext_val(xa),
        .ext_en(8'hFF), .pin_level(a_in));
    gp_pin_model pb (.clk(clk), .pin_out(b_out), .pin_oe_n(b_oe_n), .pull_up(8'h00), .ext_val(xb),
        .ext_en(8'hFF), .pin_level(b_in));
    gp_pin_model pc (.clk(clk), .pin_out(c_out), .pin_oe_n(c_oe_n), .pull_up(pull_up), .ext_val(xc),
        .ext_en(xc_en), .pin_level(c_in));

    // ----------------------------------------
    // clock, interrupt pulse monitor, tasks
    // ----------------------------------------
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    always @(posedge clk) begin
        prev_irq <= ext_irq[0];
        if (ext_irq[0] === 1'b1 && prev_irq !== 1'b1) pulses++;
    end
    task chk(string n, logic [7:0] s, logic [7:0] e);
        cmp_count++;
        if (s !== e) begin
            errors++;
            $display("MISMATCH %s expected %h seen %h", n, e, s);
        end
    endtask : chk
    task tk(int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : tk
    task wr(logic [7:0] a, logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wr_data <= d;
        wr_stb <= 1'b1;
        @(posedge clk);
        wr_stb <= 1'b0;
    endtask : wr
    task rd(logic [7:0] a, logic [7:0] e);
        @(posedge clk);
        addr <= a;
        rd_stb <= 1'b1;
        @(posedge clk);
        rd_stb <= 1'b0;
        #1;
        chk("rd_data", rd_data, e);
    endtask : rd
    task give_verdict;
        $display("comparisons %0d mismatches %0d", cmp_count, errors);
        if (errors == 0 && cmp_count > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask : give_verdict
    initial begin
        #(100 * 6000);
        errors++;
        give_verdict();
    end

    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    initial begin
        {wr_stb, rd_stb, usb_tx_enable_out, serial_enable, serial_tx_data, tx_enable} = '0;
        {ext_clock_select, timer_enable, spi_enable, pwm_out, pwm_out_enable, spi_out, spi_drive} = '0;
        addr = 8'h00; wr_data = 8'h00; adc_channel = 3'h0;
        xa = 8'hA5; xb = 8'h00; xc = 8'h00; xc_en = 8'h03;
        reset_n = 1'b0;
        repeat (3) @(posedge clk);
        reset_n <= 1'b1;
        tk(8);
        chk("a_oe_n", a_oe_n, 8'hFF);
        chk("b_oe_n", b_oe_n, 8'hFF);
        chk("pull_up", pull_up, 8'hFC);
        chk("analog_sel", analog_sel, 8'h01);
        rd(8'h00, 8'hA5);
        rd(8'h04, 8'hFC);
        wr(8'h00, 8'h5A);
        rd(8'h00, 8'hA5);
        wr(8'h01, 8'h0F);
        tk(2);
        chk("a_out", a_out & 8'h0F, 8'h0A);
        chk("a_oe_n", a_oe_n, 8'hF0);
        rd(8'h00, 8'hAA);
        wr(8'h01, 8'h00);
        // interrupt sensitivity codes on pin A0, pin idles high
        @(posedge clk) xa <= 8'hA7;
        wr(8'h08, 8'h01);
        for (int c = 0; c < 4; c++) begin
            wr(8'h0A, 8'(c));
            tk(8);
            pulses = 0;
            @(posedge clk) xa <= 8'hA6;
            tk(10);
            chk("fall pulses", 8'(pulses), 8'(c != 1));
            chk("held irq", {7'h00, ext_irq[0]}, 8'(c == 0));
            pulses = 0;
            @(posedge clk) xa <= 8'hA7;
            tk(10);
            chk("rise pulses", 8'(pulses), 8'(c % 2));
        end
        wr(8'h0A, 8'h00);
        wr(8'h01, 8'h01);
        wr(8'h08, 8'h03);
        tk(8);
        chk("irq driven pin", {5'h00, ext_irq}, 8'h00);
        @(posedge clk) xa <= 8'hA5;
        tk(8);
        chk("irq group", {5'h00, ext_irq}, 8'h01);
        wr(8'h08, 8'h00);
        wr(8'h01, 8'h00);
        for (int n = 0; n < 8; n++) begin
            @(posedge clk) adc_channel <= 3'(n);
            tk(3);
            chk("analog_sel", analog_sel, 8'h01 << n);
        end
        // alternate functions override direction bits, which stay 0
        wr(8'h0B, 8'h02);
        @(posedge clk);
        {usb_tx_enable_out, pwm_out_enable, pwm_out, tx_enable, serial_tx_data} <= 7'h77;
        {serial_enable, timer_enable, ext_clock_select, spi_enable} <= 4'hF;
        spi_drive <= 4'h4;
        xb <= 8'h2A;
        tk(8);
        chk("a0 usb", {a_out[0], a_oe_n[0]}, 8'h02);
        chk("b pwm out", b_out[7:6], 8'h01);
        chk("b pwm oe_n", b_oe_n[7:6], 8'h00);
        chk("b2 tx", {b_out[2], b_oe_n[2]}, 8'h02);
        chk("serial_rx_in", serial_rx_in, 8'h01);
        chk("timer clk", reload_timer_ext_clk, 8'h01);
        chk("capture", timer_capture_in, 8'h02);
        chk("spi_in", spi_in, 8'h0B);
        rd(8'h02, 8'h6E);
        wr(8'h0B, 8'h03);
        tk(2);
        mco_seen = b_out[0];
        tk(1);
        chk("mco", {b_out[0], b_oe_n[0]}, {~mco_seen, 1'b0});
        // open-drain pair and pull-up release
        wr(8'h05, 8'h03);
        wr(8'h04, 8'h01);
        tk(2);
        chk("c od", {c_out[1:0], c_oe_n[1:0]}, 8'h01);
        chk("pull_up", pull_up, 8'hDC);
        wr(8'h05, 8'hFF);
        tk(2);
        chk("pull_up", pull_up, 8'h00);
        rd(8'h07, 8'h00);
        wr(8'h09, 8'hFF);
        rd(8'h09, 8'h0F);
        @(posedge clk) timer_enable <= 1'b0;
        wr(8'h02, 8'h20);
        wr(8'h03, 8'h20);
        tk(2);
        chk("b5 out", {b_out[5], b_oe_n[5]}, 8'h02);
        give_verdict();
    end
endmodule : gpio_port_pin_control_test
